// *** hmtr_readout.sv ***
// measurement stop, status and double-buffered result readout
// What this block does
// - Halt bit 1 ends continuous humidity sequence
// - Halt bit 0 ends continuous temperature sequence
// - Zero halt bit leaves sensor untouched
// - State bit 1 shows humidity conversion busy
// - State bit 0 shows temperature busy, clears
// - Temperature result keeps latest finished measurement
// - Humidity result keeps latest finished measurement
// - First byte read snapshots all three bytes
// - Temperature bits 23:17 hold check value
// - Temperature bit 16 marks valid data
// - Temperature bits 15:0, 1/64 K, LSB first
// - Humidity bits 23:17 hold check value
// - Humidity bit 16 marks valid data
// - Humidity bits 15:0, 1/512 %RH, LSB first
// - Run bit picks single-shot or continuous mode
// - Start one launches, start zero does nothing
`timescale 1ns/1ps

module hmtr_readout #(
  parameter logic [6:0] CRC_POLY = 7'h09, // generator taps, arbitrary default
  parameter logic [6:0] CRC_INIT = 7'h7f  // register preset, arbitrary default
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  // byte register port, driven by the serial slave
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // run mode and start from the neighbouring control registers
  input  wire logic        temp_run_cont,
  input  wire logic        hum_run_cont,
  input  wire logic        temp_start,
  input  wire logic        hum_start,
  // converter handshake
  output logic             temp_conv_start,
  output logic             hum_conv_start,
  input  wire logic        temp_conv_done,
  input  wire logic [15:0] temp_conv_data,
  input  wire logic        hum_conv_done,
  input  wire logic [15:0] hum_conv_data,
  // status mirror
  output logic             temp_busy,
  output logic             hum_busy
);

  // crc-7 over valid flag then data, msb first
  function automatic logic [6:0] hmtr_crc7(input logic [16:0] msg);
    logic [6:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = 16; i >= 0; i--)
    begin
      fb = c[6] ^ msg[i];
      c  = {c[5:0], 1'b0};
      if (fb)
      begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

  // byte select inside a result word, byte 0 is bits 7:0
  function automatic logic [7:0] hmtr_byte(input logic [23:0] w, input logic [1:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      2'd0:    b = w[7:0];
      2'd1:    b = w[15:8];
      2'd2:    b = w[23:16];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // true when addr falls inside the three bytes of a result word
  function automatic logic hmtr_in_result(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] rel;
    rel = addr - base;
    return rel < 8'(hmtr_pkg::RES_BYTES);
  endfunction

  // status byte: one busy bit per sensor, upper bits read zero
  function automatic logic [7:0] hmtr_status(input logic [hmtr_pkg::NSENS-1:0] b);
    logic [7:0] v;
    v = 8'h00;
    v[hmtr_pkg::NSENS-1:0] = b;
    return v;
  endfunction

  logic [hmtr_pkg::NSENS-1:0]  run_cont;
  logic [hmtr_pkg::NSENS-1:0]  start_req;
  logic [hmtr_pkg::NSENS-1:0]  halt_req;
  logic [hmtr_pkg::NSENS-1:0]  conv_done;
  logic [hmtr_pkg::DATA_W-1:0] conv_data [hmtr_pkg::NSENS];
  logic [hmtr_pkg::NSENS-1:0]  busy;
  logic [hmtr_pkg::NSENS-1:0]  kick;
  logic [hmtr_pkg::RES_W-1:0]  live [hmtr_pkg::NSENS];
  logic                        hit_halt;
  logic                        hit_state;
  logic                        hit_temp0;
  logic                        hit_hum0;
  logic                        in_temp;
  logic                        in_hum;
  logic                        rd_temp0;
  logic                        rd_hum0;

  // single-address hits on the register port
  assign hit_halt  = (reg_addr == hmtr_pkg::HALT_OFF);
  assign hit_state = (reg_addr == hmtr_pkg::STATE_OFF);
  assign hit_temp0 = (reg_addr == hmtr_pkg::TEMP_OFF);
  assign hit_hum0  = (reg_addr == hmtr_pkg::HUM_OFF);

  // whole result words on the register port
  assign in_temp = hmtr_in_result(reg_addr, hmtr_pkg::TEMP_OFF);
  assign in_hum  = hmtr_in_result(reg_addr, hmtr_pkg::HUM_OFF);

  // first-byte reads, which latch a snapshot
  assign rd_temp0 = reg_rd && hit_temp0;
  assign rd_hum0  = reg_rd && hit_hum0;

  // mode and start per sensor, indexed by bit position
  assign run_cont[hmtr_pkg::TEMP_BIT]  = temp_run_cont;
  assign run_cont[hmtr_pkg::HUM_BIT]   = hum_run_cont;
  assign start_req[hmtr_pkg::TEMP_BIT] = temp_start;
  assign start_req[hmtr_pkg::HUM_BIT]  = hum_start;

  // converter answers per sensor
  assign conv_done[hmtr_pkg::TEMP_BIT] = temp_conv_done;
  assign conv_done[hmtr_pkg::HUM_BIT]  = hum_conv_done;
  assign conv_data[hmtr_pkg::TEMP_BIT] = temp_conv_data;
  assign conv_data[hmtr_pkg::HUM_BIT]  = hum_conv_data;

  // halt write: each set bit addresses its own sensor only
  always_comb
  begin
    halt_req = '0;
    if (reg_wr && hit_halt)
    begin
      halt_req = reg_wdata[hmtr_pkg::NSENS-1:0];
    end
  end

  // one sequencer and one result per sensor
  for (genvar s = 0; s < hmtr_pkg::NSENS; s++)
  begin : g_sens
    hmtr_pkg::hmtr_state_t       state_q;
    logic                        kick_q;
    logic [hmtr_pkg::DATA_W-1:0] data_q;
    logic                        valid_q;
    logic                        halt_go;
    logic                        take;
    logic [hmtr_pkg::CRC_W-1:0]  crc;

    // halt only counts in continuous mode; a done in the halt cycle is dropped
    assign halt_go = halt_req[s] && run_cont[s];
    assign take    = (state_q == hmtr_pkg::HMTR_MEAS) && conv_done[s] && !halt_go;

    // sequencer: start launches, done ends or re-arms, halt aborts continuous
    always_ff @(posedge core_clk or posedge reset)
    begin
      if (reset)
      begin
        state_q <= hmtr_pkg::HMTR_IDLE;
      end
      else
      begin
        case (state_q)
          hmtr_pkg::HMTR_IDLE:
          begin
            if (start_req[s])
            begin
              state_q <= hmtr_pkg::HMTR_MEAS;
            end
          end
          hmtr_pkg::HMTR_MEAS:
          begin
            if (halt_go)
            begin
              state_q <= hmtr_pkg::HMTR_IDLE;
            end
            else if (conv_done[s] && !run_cont[s])
            begin
              state_q <= hmtr_pkg::HMTR_IDLE;
            end
          end
          default:
          begin
            state_q <= hmtr_pkg::HMTR_IDLE;
          end
        endcase
      end
    end

    // converter kick: one pulse per launch, again after each continuous done
    always_ff @(posedge core_clk or posedge reset)
    begin
      if (reset)
      begin
        kick_q <= 1'b0;
      end
      else if (state_q == hmtr_pkg::HMTR_IDLE)
      begin
        kick_q <= start_req[s];
      end
      else
      begin
        kick_q <= take && run_cont[s];
      end
    end

    // live data: overwritten by each finished conversion
    always_ff @(posedge core_clk or posedge reset)
    begin
      if (reset)
      begin
        data_q <= hmtr_pkg::DATA_RST;
      end
      else if (take)
      begin
        data_q <= conv_data[s];
      end
    end

    // valid flag: set by the first finished conversion, cleared by reset only
    always_ff @(posedge core_clk or posedge reset)
    begin
      if (reset)
      begin
        valid_q <= 1'b0;
      end
      else if (take)
      begin
        valid_q <= 1'b1;
      end
    end

    assign busy[s] = (state_q == hmtr_pkg::HMTR_MEAS);
    assign kick[s] = kick_q;

    // check value over valid flag then data
    assign crc = hmtr_crc7({valid_q, data_q});
    // pack check value, valid flag and data
    assign live[s] = {crc, valid_q, data_q};
  end

  assign temp_conv_start = kick[hmtr_pkg::TEMP_BIT];
  assign hum_conv_start  = kick[hmtr_pkg::HUM_BIT];
  assign temp_busy       = busy[hmtr_pkg::TEMP_BIT];
  assign hum_busy        = busy[hmtr_pkg::HUM_BIT];

  logic [hmtr_pkg::RES_W-1:0] temp_snap_q;
  logic [hmtr_pkg::RES_W-1:0] hum_snap_q;

  // temperature snapshot: taken on a read of its first byte
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      temp_snap_q <= hmtr_pkg::RESULT_RST;
    end
    else if (rd_temp0)
    begin
      temp_snap_q <= live[hmtr_pkg::TEMP_BIT];
    end
  end

  // humidity snapshot: taken on a read of its first byte
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      hum_snap_q <= hmtr_pkg::RESULT_RST;
    end
    else if (rd_hum0)
    begin
      hum_snap_q <= live[hmtr_pkg::HUM_BIT];
    end
  end

  logic [7:0] rd_byte;
  logic [7:0] rel_t;
  logic [7:0] rel_h;
  logic [7:0] temp_byte;
  logic [7:0] hum_byte;

  assign rel_t = reg_addr - hmtr_pkg::TEMP_OFF;
  assign rel_h = reg_addr - hmtr_pkg::HUM_OFF;

  // temperature bytes: first from the live word, later ones from the snapshot
  always_comb
  begin
    temp_byte = hmtr_byte(temp_snap_q, rel_t[1:0]);
    if (hit_temp0)
    begin
      temp_byte = live[hmtr_pkg::TEMP_BIT][7:0];
    end
  end

  // humidity bytes: first from the live word, later ones from the snapshot
  always_comb
  begin
    hum_byte = hmtr_byte(hum_snap_q, rel_h[1:0]);
    if (hit_hum0)
    begin
      hum_byte = live[hmtr_pkg::HUM_BIT][7:0];
    end
  end

  // read decode: unmapped and write-only addresses read zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_state)
    begin
      rd_byte = hmtr_status(busy);
    end
    else if (in_temp)
    begin
      rd_byte = temp_byte;
    end
    else if (in_hum)
    begin
      rd_byte = hum_byte;
    end
  end

  // read data register, loaded on each read strobe
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= hmtr_pkg::RDATA_RST;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rd_byte;
    end
  end

endmodule

// *** hmtr_pkg.sv ***
// constants and types shared by the humidity and temperature readout block
package hmtr_pkg;
  // byte offsets on the register port
  localparam logic [7:0] HALT_OFF  = 8'h23;
  localparam logic [7:0] STATE_OFF = 8'h24;
  localparam logic [7:0] TEMP_OFF  = 8'h30;
  localparam logic [7:0] HUM_OFF   = 8'h33;
  localparam int         RES_BYTES = 3;

  // sensor index doubles as bit position in halt and state registers
  localparam int TEMP_BIT = 0;
  localparam int HUM_BIT  = 1;
  localparam int NSENS    = 2;

  // result field layout
  localparam int DATA_W    = 16;
  localparam int VALID_POS = 16;
  localparam int CRC_LSB   = 17;
  localparam int CRC_W     = 7;
  localparam int RES_W     = 24;

  // reset values
  localparam logic [7:0]       RDATA_RST  = 8'h00;
  localparam logic [RES_W-1:0] RESULT_RST = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;

  // per-sensor sequencer states, one-hot
  typedef enum logic [1:0] {
    HMTR_IDLE = 2'b01,
    HMTR_MEAS = 2'b10
  } hmtr_state_t;
endpackage

// *** hmtr_readout_chk.sv ***
// port assertions for the readout block
`timescale 1ns/1ps
module hmtr_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        temp_run_cont,
  input wire logic        hum_run_cont,
  input wire logic        temp_start,
  input wire logic        temp_conv_start,
  input wire logic        temp_conv_done,
  input wire logic [15:0] temp_conv_data,
  input wire logic        temp_busy,
  input wire logic        hum_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // halt register write seen this cycle
  wire halt_w = reg_wr && reg_addr == 8'h23;
  sequence t_fin;
    temp_busy && temp_conv_done && !halt_w
    ##1 reg_rd && reg_addr == 8'h30 && !temp_conv_done;
  endsequence
  chk_start_launch: assert property (
    temp_start && !temp_busy |=> temp_busy && temp_conv_start)
    else $error("start did not launch");
  chk_conv_pulse: assert property (temp_conv_start |=> !temp_conv_start)
    else $error("conversion start too long");
  chk_halt_temp: assert property (
    halt_w && reg_wdata[0] && temp_busy && temp_run_cont |=> !temp_busy)
    else $error("temperature halt ignored");
  chk_halt_hum: assert property (
    halt_w && reg_wdata[1] && hum_busy && hum_run_cont |=> !hum_busy)
    else $error("humidity halt ignored");
  chk_halt_zero: assert property (
    halt_w && !reg_wdata[0] && temp_busy && !temp_conv_done |=> temp_busy)
    else $error("zero halt bit stopped sensor");
  chk_state_read: assert property (
    reg_rd && reg_addr == 8'h24 |=>
    reg_rdata == {6'h00, $past(hum_busy), $past(temp_busy)})
    else $error("status byte wrong");
  chk_single_end: assert property (
    temp_busy && !temp_run_cont && temp_conv_done |=> !temp_busy)
    else $error("single shot kept running");
  chk_cont_again: assert property (
    temp_busy && temp_run_cont && temp_conv_done && !halt_w |=> temp_conv_start && temp_busy)
    else $error("continuous did not restart");
  chk_wo_read: assert property (reg_rd && reg_addr == 8'h23 |=> reg_rdata == 8'h00)
    else $error("halt register readable");
  chk_temp_latest: assert property (
    t_fin |=> reg_rdata == $past(temp_conv_data[7:0], 2))
    else $error("temperature low byte stale");
endmodule
bind hmtr_readout hmtr_chk u_chk (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .temp_run_cont(temp_run_cont), .temp_start(temp_start), .temp_conv_start(temp_conv_start),
  .temp_conv_done(temp_conv_done), .temp_conv_data(temp_conv_data), .temp_busy(temp_busy),
  .hum_busy(hum_busy), .hum_run_cont(hum_run_cont));

// *** hmtr_conv_model.sv ***
// converter stand-in answering each start after a fixed delay
`timescale 1ns/1ps
module hmtr_conv_model #(
  parameter int DLY = 6
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [15:0] val,
  output logic             done,
  output logic [15:0]      data
);
  int cnt;
  // countdown from each start, done pulse at the end
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt  <= 0;
      done <= 1'b0;
    end
    else
    begin
      cnt  <= go ? DLY : (cnt > 0 ? cnt - 1 : 0);
      done <= cnt == 1;
    end
  // data line not held outside done
  assign data = done ? val : ~val;
endmodule

// *** test_humidity_temp_meas_readout.sv ***
// self-checking bench for the readout block
`timescale 1ns/1ps
module test_humidity_temp_meas_readout;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, t_cont = 1'b0, h_cont = 1'b0;
  logic        t_go = 1'b0, h_go = 1'b0, t_cs, h_cs, t_dn, h_dn, t_busy, h_busy;
  logic [15:0] t_data, h_data, temperature_result = 16'h1234, humidity_result = 16'hbeef;
  int          n_errors = 0, samples_checked = 0, cycles = 0;
  hmtr_readout uut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_run_cont(t_cont),
    .hum_run_cont(h_cont), .temp_start(t_go), .hum_start(h_go), .temp_conv_start(t_cs),
    .hum_conv_start(h_cs), .temp_conv_done(t_dn), .temp_conv_data(t_data),
    .hum_conv_done(h_dn), .hum_conv_data(h_data), .temp_busy(t_busy), .hum_busy(h_busy));
  hmtr_conv_model u_tc (.clk(core_clk), .rst(reset), .go(t_cs), .val(temperature_result), .done(t_dn),
    .data(t_data));
  hmtr_conv_model u_hc (.clk(core_clk), .rst(reset), .go(h_cs), .val(humidity_result), .done(h_dn),
    .data(h_data));
  // clock and hang guard
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      test_done();
    end
  end
  function automatic logic [6:0] crc7(input logic [16:0] m);
    logic [6:0] c;
    c = 7'h7f;
    for (int i = 16; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((c[6] ^ m[i]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    chk8(reg_rdata, e);
  endtask
  task wr(input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_wr = 1'b1;
    reg_addr = 8'h23;
    reg_wdata = d;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
  endtask
  task go(input logic t, input logic h);
    @(posedge core_clk);
    #1 t_go = t;
    h_go = h;
    @(posedge core_clk);
    #1 t_go = 1'b0;
    h_go = 1'b0;
  endtask
  task res(input logic [7:0] a, input logic [15:0] v, input logic ok);
    rd(a, v[7:0]);
    rd(a + 8'h01, v[15:8]);
    rd(a + 8'h02, {crc7({ok, v}), ok});
  endtask
  task test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    rd(8'h24, 8'h00);
    rd(8'h23, 8'h00);
    rd(8'h40, 8'h00);
    res(8'h30, 16'h0000, 1'b0);
    go(1'b1, 1'b0);
    repeat (40) if (t_busy === 1'b1) @(posedge core_clk) #1;
    rd(8'h24, 8'h00);
    res(8'h30, 16'h1234, 1'b1);
    rd(8'h30, 8'h34);
    temperature_result = 16'h5678;
    go(1'b1, 1'b0);
    repeat (40) if (t_busy === 1'b1) @(posedge core_clk) #1;
    rd(8'h31, 8'h12);
    res(8'h30, 16'h5678, 1'b1);
    h_cont = 1'b1;
    go(1'b0, 1'b1);
    repeat (20) @(posedge core_clk);
    rd(8'h24, 8'h02);
    wr(8'h01);
    rd(8'h24, 8'h02);
    wr(8'h02);
    rd(8'h24, 8'h00);
    res(8'h33, 16'hbeef, 1'b1);
    t_cont = 1'b1;
    go(1'b1, 1'b1);
    repeat (20) @(posedge core_clk);
    wr(8'hfd);
    rd(8'h24, 8'h02);
    wr(8'h02);
    go(1'b0, 1'b0);
    rd(8'h24, 8'h00);
    test_done();
  end
endmodule
